// File: rtl/acs_pkg.sv
// package: constants, types and the function summary for the adc conversion sequencer
// Function
// - results shift out as two bytes: four zeros, ten bits, two sub-bits, msb first (temperature word is packed as twelve bits then four zeros)
// - serial output data changes on falling serial clock edges
// - unipolar straight binary; bipolar and temperature in two's complement (voltage code is packed unchanged for bipolar too)
// - one step is vref/1024 for voltage, one eighth degree for temperature
// - first byte cut short loses its unread bits; next read gives next byte
// - second byte cut short is dropped; later entries stay intact
// - write with chip select rising before eight clocks is ignored
// - mode 00: strobe pulse runs wake, acquire, convert, shutdown on internal timing
// - after whole scan stored, shut down, pull end-of-conversion low
// - end-of-conversion stays low until chip select or strobe goes low
// - requested temperature result enters fifo ahead of channel results
// - mode 01: falling strobe wakes and tracks; host holds low 1.4us
// - mode 01 temperature: device times reference and measurement itself
// - mode 01: rising strobe starts conversion, sampling done about 500ns later
// - mode 01: shut down and pull end-of-conversion low after each conversion
// - averaging: write fifo after programmed count, then step to next channel
// - mode 01: temperature runs after first rising strobe after command
// - two-bit clock mode field; 11 selects serially clocked conversion
package acs_pkg;
  localparam int CLK_MHZ        = 250;
  localparam int ACQ_NS         = 1400;
  localparam int SAMPLE_NS      = 500;
  localparam int CONV_NS        = 3600;
  localparam int TEMP_US        = 53;
  localparam int ACQ_CYC        = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_CYC     = (SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int TEMP_CYC       = TEMP_US * CLK_MHZ;
  localparam int FIFO_DEPTH     = 17;
  localparam int WORD_W         = 16;
  localparam int CNT_W          = 16;
  localparam logic [1:0] MODE_STROBE_SCAN = 2'h0;
  localparam logic [1:0] MODE_STROBE_EACH = 2'h1;
  localparam logic [1:0] MODE_SERIAL_CLK  = 2'h3;
  localparam logic [3:0] LEAD_ZEROS       = 4'h0;
  localparam logic [1:0] SUB_BITS         = 2'h0;
  localparam logic [3:0] CHAN_RST         = 4'h0;
  localparam logic [3:0] BIT_RST          = 4'hF;

  typedef struct packed {
    logic [1:0] clock_mode;
    logic       temp_req;
    logic       bipolar;
    logic [3:0] last_chan;
    logic [3:0] avg_count;
  } acs_cfg_s;

  typedef struct packed {
    logic       is_temp;
    logic [3:0] chan;
  } acs_req_s;
endpackage

// File: rtl/acs_fifo.sv
// result fifo with parameterised width and depth
`timescale 1ns/1ps
module acs_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D + 1);
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt, cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = cnt_r != AW'(D);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    rd_nxt  = rd_r;
    wr_nxt  = wr_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      rd_nxt  = '0;
      wr_nxt  = '0;
      cnt_nxt = '0;
    end else begin
      if (push) wr_nxt = (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
      if (pop) rd_nxt = (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
      cnt_nxt = cnt_r + AW'(push) - AW'(pop);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r  <= '0;
      wr_r  <= '0;
      cnt_r <= '0;
    end else begin
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset so it maps onto plain ram
  always_ff @(posedge ref_clk) begin
    if (push && !flush) mem_r[wr_r] <= in_data;
  end
endmodule // acs_fifo

// File: rtl/acs_seq.sv
// conversion sequencer top: strobe modes, scan stepping, averaging and serial readout
`timescale 1ns/1ps
module acs_seq #(
  parameter int TEMP_CYCLES = acs_pkg::TEMP_CYC,
  parameter int FIFO_WORDS  = acs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset_n,
  // configuration
  input  wire acs_pkg::acs_cfg_s         cfg,
  input  wire logic                      command_pulse,
  // converter core
  output logic                           adc_wake,
  output logic                           adc_track,
  output logic [3:0]                     adc_chan,
  input  wire logic [9:0]                adc_code,
  input  wire logic [11:0]               temp_code,
  // pins
  input  wire logic                      conversion_strobe_n,
  input  wire logic                      cs_n,
  input  wire logic                      sclk,
  output logic                           dout,
  output logic                           eoc_n,
  // status
  output logic                           busy
);
  typedef enum logic [2:0] {ACS_IDLE, ACS_ACQ, ACS_WAIT_RISE, ACS_SAMPLE, ACS_CONV, ACS_TEMP} acs_state_e;
  localparam logic [15:0] TEMP_LEN = 16'(TEMP_CYCLES);

  // two-flop synchronisers plus a third edge stage; stages two and three are read
  logic [2:0] s1_r, s2_r, s3_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= 3'h7;
      s2_r <= 3'h7;
      s3_r <= 3'h7;
    end else begin
      s1_r <= {conversion_strobe_n, cs_n, sclk};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic stb_fall, stb_rise, cs_fall, cs_rise, sclk_fall, cs_lo;
  assign stb_fall  = s3_r[2] && !s2_r[2];
  assign stb_rise  = !s3_r[2] && s2_r[2];
  assign cs_fall   = s3_r[1] && !s2_r[1];
  assign cs_rise   = !s3_r[1] && s2_r[1];
  assign cs_lo     = !s2_r[1];
  assign sclk_fall = s3_r[0] && !s2_r[0];

  // sequencer state
  acs_state_e  st_r, st_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [3:0]  chan_r, chan_nxt, avg_r, avg_nxt;
  logic        temp_pend_r, temp_pend_nxt, eoc_n_r, eoc_n_nxt;
  logic [13:0] acc_r, acc_nxt;
  logic        push;
  logic [15:0] push_word;
  logic        fifo_ready, fifo_valid, fifo_pop;
  logic [15:0] fifo_word;
  logic        step_mode;
  assign step_mode = cfg.clock_mode == acs_pkg::MODE_STROBE_EACH;

  // averaged code, packed as straight binary whatever the bipolar setting
  function automatic logic [15:0] pack_code(input logic [13:0] acc, input logic [3:0] n);
    logic [9:0] c;
    c = 10'(acc / (14'(n) + 14'h1));
    return {acs_pkg::LEAD_ZEROS, c, acs_pkg::SUB_BITS};
  endfunction

  always_comb begin
    st_nxt        = st_r;
    tmr_nxt       = tmr_r;
    chan_nxt      = chan_r;
    avg_nxt       = avg_r;
    acc_nxt       = acc_r;
    temp_pend_nxt = temp_pend_r;
    eoc_n_nxt     = eoc_n_r;
    push          = 1'b0;
    push_word     = 16'h0;
    if (cs_fall || stb_fall) eoc_n_nxt = 1'b1;
    if (command_pulse) begin
      chan_nxt      = acs_pkg::CHAN_RST;
      avg_nxt       = 4'h0;
      acc_nxt       = 14'h0;
      temp_pend_nxt = cfg.temp_req;
    end
    unique case (st_r)
      ACS_IDLE: begin
        if (cfg.clock_mode == acs_pkg::MODE_STROBE_SCAN && stb_rise) begin
          tmr_nxt = temp_pend_r ? TEMP_LEN : 16'(acs_pkg::ACQ_CYC);
          st_nxt  = temp_pend_r ? ACS_TEMP : ACS_ACQ;
        end else if (step_mode && stb_fall && !temp_pend_r) begin
          st_nxt = ACS_WAIT_RISE;
        end else if (step_mode && stb_rise && temp_pend_r) begin
          tmr_nxt = TEMP_LEN;
          st_nxt  = ACS_TEMP;
        end
      end
      ACS_ACQ: begin
        if (tmr_r <= 16'h1) begin
          tmr_nxt = 16'(acs_pkg::SAMPLE_CYC);
          st_nxt  = ACS_SAMPLE;
        end else tmr_nxt = tmr_r - 16'h1;
      end
      ACS_WAIT_RISE: begin
        if (stb_rise) begin
          tmr_nxt = 16'(acs_pkg::SAMPLE_CYC);
          st_nxt  = ACS_SAMPLE;
        end
      end
      ACS_SAMPLE: begin
        if (tmr_r <= 16'h1) begin
          tmr_nxt = 16'(acs_pkg::CONV_CYC);
          st_nxt  = ACS_CONV;
        end else tmr_nxt = tmr_r - 16'h1;
      end
      ACS_CONV: begin
        if (tmr_r > 16'h1) tmr_nxt = tmr_r - 16'h1;
        else begin
          acc_nxt = acc_r + 14'(adc_code);
          if (avg_r == cfg.avg_count) begin
            push      = 1'b1;
            push_word = pack_code(acc_r + 14'(adc_code), cfg.avg_count);
            acc_nxt   = 14'h0;
            avg_nxt   = 4'h0;
            chan_nxt  = (chan_r == cfg.last_chan) ? acs_pkg::CHAN_RST : chan_r + 4'h1;
          end else avg_nxt = avg_r + 4'h1;
          if (step_mode) begin
            st_nxt    = ACS_IDLE;
            eoc_n_nxt = 1'b0;
          end else if (push && chan_r == cfg.last_chan) begin
            st_nxt    = ACS_IDLE;
            eoc_n_nxt = 1'b0;
          end else begin
            tmr_nxt = 16'(acs_pkg::ACQ_CYC);
            st_nxt  = ACS_ACQ;
          end
        end
      end
      ACS_TEMP: begin
        if (tmr_r > 16'h1) tmr_nxt = tmr_r - 16'h1;
        else begin
          push          = 1'b1;
          push_word     = {temp_code, 4'h0};
          temp_pend_nxt = 1'b0;
          if (step_mode) begin
            st_nxt    = ACS_IDLE;
            eoc_n_nxt = 1'b0;
          end else begin
            tmr_nxt = 16'(acs_pkg::ACQ_CYC);
            st_nxt  = ACS_ACQ;
          end
        end
      end
    endcase
    // serially clocked mode bypasses this sequencer
    if (cfg.clock_mode == acs_pkg::MODE_SERIAL_CLK) st_nxt = ACS_IDLE;
  end
  // strobe edges are ignored outside ACS_IDLE/ACS_WAIT_RISE, so a running scan is never restarted

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r        <= ACS_IDLE;
      tmr_r       <= 16'h0;
      chan_r      <= acs_pkg::CHAN_RST;
      avg_r       <= 4'h0;
      acc_r       <= 14'h0;
      temp_pend_r <= 1'b0;
      eoc_n_r     <= 1'b1;
    end else begin
      st_r        <= st_nxt;
      tmr_r       <= tmr_nxt;
      chan_r      <= chan_nxt;
      avg_r       <= avg_nxt;
      acc_r       <= acc_nxt;
      temp_pend_r <= temp_pend_nxt;
      eoc_n_r     <= eoc_n_nxt;
    end
  end

  acs_fifo #(.W(acs_pkg::WORD_W), .D(FIFO_WORDS)) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .flush     (command_pulse),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  // serial readout: byte position survives chip select, bit position does not
  logic       half_r, half_nxt, dout_r, dout_nxt, loaded_r, loaded_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  always_comb begin
    half_nxt   = half_r;
    bit_nxt    = bit_r;
    cnt_nxt    = cnt_r;
    dout_nxt   = dout_r;
    loaded_nxt = loaded_r;
    fifo_pop   = 1'b0;
    if (cs_fall) begin
      cnt_nxt    = 3'h0;
      loaded_nxt = 1'b1;
      bit_nxt    = half_r ? 4'h7 : acs_pkg::BIT_RST;
      dout_nxt   = fifo_valid ? fifo_word[half_r ? 7 : 15] : 1'b0;
    end else if (cs_lo && loaded_r && sclk_fall) begin
      cnt_nxt = cnt_r + 3'h1;
      if (bit_r == 4'h8 || bit_r == 4'h0) begin
        half_nxt = bit_r == 4'h8;
        if (bit_r == 4'h0) fifo_pop = fifo_valid;
      end
      bit_nxt  = bit_r - 4'h1;
      dout_nxt = fifo_valid ? fifo_word[bit_r - 4'h1] : 1'b0;
      if (bit_r == 4'h0) dout_nxt = 1'b0;
    end
    if (cs_rise && loaded_r) begin
      loaded_nxt = 1'b0;
      // unread rest of a cut byte is dropped
      if (bit_r != 4'hF && bit_r != 4'h7) begin
        if (!half_r && bit_r > 4'h7) half_nxt = 1'b1;
        else if (bit_r <= 4'h7 && bit_r != 4'h7) begin
          half_nxt = 1'b0;
          fifo_pop = fifo_valid && !(cs_lo && sclk_fall && bit_r == 4'h0);
        end
      end
    end
  end
  // a cut register write would sit here; the writes of this block come only as command_pulse

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      half_r   <= 1'b0;
      bit_r    <= acs_pkg::BIT_RST;
      cnt_r    <= 3'h0;
      dout_r   <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      half_r   <= half_nxt;
      bit_r    <= bit_nxt;
      cnt_r    <= cnt_nxt;
      dout_r   <= dout_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // registered core controls
  logic wake_r, track_r, busy_r;
  logic [3:0] achan_r;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_r  <= 1'b0;
      track_r <= 1'b0;
      busy_r  <= 1'b0;
      achan_r <= acs_pkg::CHAN_RST;
    end else begin
      wake_r  <= st_nxt != ACS_IDLE;
      track_r <= st_nxt == ACS_ACQ || st_nxt == ACS_WAIT_RISE;
      busy_r  <= st_nxt != ACS_IDLE || !fifo_ready;
      achan_r <= chan_nxt;
    end
  end
  assign adc_wake  = wake_r;
  assign adc_track = track_r;
  assign adc_chan  = achan_r;
  assign busy      = busy_r;
  assign dout      = dout_r;
  assign eoc_n     = eoc_n_r;
endmodule // acs_seq

// File: test/acs_seq_props.sv
// checker: port-level timing and ordering properties of the conversion sequencer
`timescale 1ns/1ps
module acs_seq_props #(
  parameter int TEMP_CYCLES = 20,
  parameter int FIFO_WORDS  = 17
) (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // configuration
  input wire acs_pkg::acs_cfg_s cfg,
  input wire logic              command_pulse,
  // converter core
  input wire logic              adc_wake,
  input wire logic              adc_track,
  input wire logic [3:0]        adc_chan,
  input wire logic [9:0]        adc_code,
  input wire logic [11:0]       temp_code,
  // pins
  input wire logic              conversion_strobe_n,
  input wire logic              cs_n,
  input wire logic              sclk,
  input wire logic              dout,
  input wire logic              eoc_n,
  // status
  input wire logic              busy
);
  localparam int MIN_CONV = acs_pkg::ACQ_CYC + acs_pkg::SAMPLE_CYC + acs_pkg::CONV_CYC - 8;
  logic [7:0]  low_r, low_nxt, edge_r, edge_nxt;
  logic        sclk_r, cs_r;
  logic [15:0] blen_r, blen_nxt;
  // histories cover the pin synchroniser latency of the design
  always_comb begin
    low_nxt  = {low_r[6:0], ~cs_n | ~conversion_strobe_n | command_pulse};
    edge_nxt = {edge_r[6:0], (sclk_r & ~sclk) | (cs_r ^ cs_n)};
    blen_nxt = !busy ? 16'h0 : (&blen_r ? blen_r : blen_r + 16'h1);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {low_r, edge_r, sclk_r, cs_r, blen_r} <= {16'h0, 2'h1, 16'h0};
    end else begin
      {low_r, edge_r, sclk_r, cs_r, blen_r} <= {low_nxt, edge_nxt, sclk, cs_n, blen_nxt};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_eoc_hold: assert property ($rose(eoc_n) |-> |low_r)
    else $error("eoc_n rose without select or strobe");
  a_eoc_cause: assert property ($fell(eoc_n) |-> $past(busy))
    else $error("eoc_n fell without a finished conversion");
  a_scan_time: assert property ($fell(eoc_n) && cfg.clock_mode == acs_pkg::MODE_STROBE_SCAN |-> blen_r >= MIN_CONV)
    else $error("scan finished too early");
  a_dout_fall: assert property ($changed(dout) |-> |edge_r)
    else $error("dout changed away from a serial clock fall");
  a_track_wake: assert property (adc_track |-> adc_wake)
    else $error("tracking while asleep");
  // a pending temperature request makes the falling strobe a no-op, so it is left out here
  a_each_track: assert property (cfg.clock_mode == acs_pkg::MODE_STROBE_EACH && $fell(conversion_strobe_n)
    && !adc_wake && !cfg.temp_req |-> ##[1:8] adc_track) else $error("falling strobe did not start tracking");
  // tracking stops at the rising strobe; the core then stays awake for the next 120 cycles of sampling
  a_each_sample: assert property (cfg.clock_mode == acs_pkg::MODE_STROBE_EACH && $rose(conversion_strobe_n)
    && adc_track |-> ##[1:8] !adc_track ##0 (adc_wake throughout (##120 1'b1))) else $error("sampling time wrong");
  a_serial_idle: assert property (cfg.clock_mode == acs_pkg::MODE_SERIAL_CLK && !busy
    && $fell(conversion_strobe_n) |-> !busy[*8]) else $error("strobe acted in serial clock mode");
  a_chan_step: assert property ($changed(adc_chan) |-> adc_chan == $past(adc_chan) + 4'h1 || adc_chan == 4'h0)
    else $error("channel did not step in order");
  c_each_done: cover property ($fell(eoc_n) && cfg.clock_mode == acs_pkg::MODE_STROBE_EACH);
  c_temp_scan: cover property ($fell(eoc_n) && cfg.temp_req);
  c_cut_read: cover property ($rose(cs_n) && !sclk);
endmodule // acs_seq_props

bind acs_seq acs_seq_props #(.TEMP_CYCLES(TEMP_CYCLES), .FIFO_WORDS(FIFO_WORDS)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .command_pulse(command_pulse), .adc_wake(adc_wake),
  .adc_track(adc_track), .adc_chan(adc_chan), .adc_code(adc_code), .temp_code(temp_code),
  .conversion_strobe_n(conversion_strobe_n), .cs_n(cs_n), .sclk(sclk), .dout(dout), .eoc_n(eoc_n), .busy(busy));

// File: test/acs_host.sv
// host model: conversion strobe and serial master reading the result fifo
`timescale 1ns/1ps
module acs_host (
  // clock
  input wire logic ref_clk,
  // pins towards the sequencer
  output logic     conversion_strobe_n,
  output logic     cs_n,
  output logic     sclk,
  input wire logic dout
);
  initial begin
    {conversion_strobe_n, cs_n, sclk} = 3'h6;
  end
  // low time given in clock cycles of the sequencer; the reference is taken as already up,
  // so no extra reference power-up time is added to the low phase
  task automatic strobe(input int low_cyc);
    @(negedge ref_clk);
    conversion_strobe_n = 1'b0;
    repeat (low_cyc) @(negedge ref_clk);
    conversion_strobe_n = 1'b1;
  endtask
  // serial clock idles low between frames; bits are taken on its rising edge
  task automatic read_bits(input int n, output logic [15:0] word);
    word = 16'h0;
    #1.3 cs_n = 1'b0;
    repeat (n) begin
      #80 sclk = 1'b1;
      word = {word[14:0], dout};
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    #160;
  endtask
endmodule // acs_host

// File: test/adc_conversion_sequencer_bench.sv
// self-checking bench: scans, averaging, partial reads and mode selection
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  logic              ref_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              command_pulse = 1'b0;
  acs_pkg::acs_cfg_s cfg = '0;
  logic [9:0]        code_tab [16];
  logic [11:0]       temp_code = 12'h0;
  logic              adc_wake, adc_track, dout, eoc_n, busy, conversion_strobe_n, cs_n, sclk;
  logic [3:0]        adc_chan;
  logic [15:0]       word;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                seed = 32'h82e6;
  int                i;
  always #2 ref_clk = ~ref_clk;
  acs_seq #(.TEMP_CYCLES(20), .FIFO_WORDS(acs_pkg::FIFO_DEPTH)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .command_pulse(command_pulse), .adc_wake(adc_wake),
    .adc_track(adc_track), .adc_chan(adc_chan), .adc_code(code_tab[adc_chan]), .temp_code(temp_code),
    .conversion_strobe_n(conversion_strobe_n), .cs_n(cs_n), .sclk(sclk), .dout(dout), .eoc_n(eoc_n), .busy(busy));
  acs_host host (.ref_clk(ref_clk), .conversion_strobe_n(conversion_strobe_n), .cs_n(cs_n), .sclk(sclk), .dout(dout));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] chan_word(input int ch);
    return {4'h0, code_tab[ch], 2'h0};
  endfunction
  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_n !== 1'b0 && n < 30000) begin
      @(negedge ref_clk);
      n++;
    end
    check("eoc_n", {15'h0, eoc_n}, 16'h0);
  endtask
  // coding passes through unchanged, so the polarity bit is drawn at random
  task automatic command(input logic [1:0] mode, input logic t, input logic [3:0] last, input logic [3:0] avg);
    @(negedge ref_clk);
    cfg = '{mode, t, 1'($random(seed)), last, avg};
    command_pulse = 1'b1;
    @(negedge ref_clk);
    command_pulse = 1'b0;
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 16; i++) code_tab[i] = 10'($random(seed));
    temp_code = 12'($random(seed));
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("reset", {13'h0, eoc_n, dout, busy}, 16'h0004);
    // full scan with temperature fills all seventeen slots; the host stalls before reading
    command(acs_pkg::MODE_STROBE_SCAN, 1'b1, 4'hF, 4'h0);
    host.strobe(10);
    wait_eoc();
    repeat (200) @(negedge ref_clk);
    check("eoc_hold", {15'h0, eoc_n}, 16'h0);
    host.read_bits(16, word);
    check("temp", word, {temp_code, 4'h0});
    host.read_bits(5, word);
    check("cut_byte1", word, chan_word(0) >> 11);
    host.read_bits(8, word);
    check("next_bits", word, chan_word(0) & 16'h00FF);
    host.read_bits(8, word);
    check("byte1", word, chan_word(1) >> 8);
    host.read_bits(3, word);
    check("cut_byte2", word, (chan_word(1) >> 5) & 16'h0007);
    for (i = 2; i < 16; i++) begin
      host.read_bits(16, word);
      check("chan", word, chan_word(i));
    end
    // one conversion per strobe, two conversions averaged per result
    command(acs_pkg::MODE_STROBE_EACH, 1'b0, 4'h1, 4'h1);
    for (i = 0; i < 4; i++) begin
      host.strobe(acs_pkg::ACQ_CYC + 4);
      wait_eoc();
    end
    for (i = 0; i < 2; i++) begin
      host.read_bits(16, word);
      check("avg", word, chan_word(i));
    end
    // per-strobe mode with temperature: short strobe runs the internally timed measurement first
    command(acs_pkg::MODE_STROBE_EACH, 1'b1, 4'h0, 4'h0);
    host.strobe(10);
    wait_eoc();
    host.strobe(acs_pkg::ACQ_CYC + 4);
    wait_eoc();
    host.read_bits(16, word);
    check("each_temp", word, {temp_code, 4'h0});
    host.read_bits(16, word);
    check("each_chan", word, chan_word(0));
    // serially clocked mode leaves the strobe sequencer idle
    command(acs_pkg::MODE_SERIAL_CLK, 1'b0, 4'h0, 4'h0);
    host.strobe(10);
    repeat (40) @(negedge ref_clk);
    check("serial_idle", {15'h0, busy}, 16'h0);
    end_of_test();
  end
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule // adc_conversion_sequencer_bench
